// ==== src/hot_swap_cfg.svh ====
`ifndef HOT_SWAP_CFG_SVH
`define HOT_SWAP_CFG_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define NS_PER_MS       1000000
`define CC_MAX_MS       150
`define CC_CODE_MAX     255
`define VF_UNIT_MS      1
`define VF_LEN_0        5'h00
`define VF_LEN_1        5'h01
`define VF_LEN_2        5'h04
`define VF_LEN_3        5'h10

// ---------------------------------------------------------------
// Memory sizes and serial framing
// ---------------------------------------------------------------
`define NUM_CH          4
`define USER_BITS       64
`define TRIM_BITS       17
`define ADDR_W          7
`define ADDR_LAST       7'h50
`define TRIM_BASE       7'h40
`define HDR_BITS        4'h8

// ---------------------------------------------------------------
// Field positions inside the user memory
// ---------------------------------------------------------------
`define UVR_LSB         0
`define UVT_LSB         8
`define ILR_LSB         24
`define ILT_LSB         32
`define CCT_LSB         48
`define ORD_LSB         56
`define RSP_LATCH       59
`define RSP_RAMPDN      60
`define RSP_VF_LSB      61
`define LOCK_BIT        63

`endif

// ==== src/hot_swap_pkg.sv ====
package hot_swap_pkg;

	// Analog settings handed to comparators and current amplifiers
	typedef struct packed {
		logic [7:0]  undervoltage_coarse_range;
		logic [15:0] uv_trim;
		logic [7:0]  ilim_range;
		logic [15:0] ilim_trim;
	} cfg_out_t;

	// Per-channel results from the analog front end
	typedef struct packed {
		logic [3:0] uv_ok;
		logic [3:0] in_cc;
		logic [3:0] oc_trip;
	} ana_in_t;

	// Decoded levels of the single-pin serial link
	typedef struct packed {
		logic frame;
		logic clk;
		logic data;
	} link_in_t;

	typedef enum logic [5:0] {
		ST_SLEEP = 6'b000001,
		ST_LOAD  = 6'b000010,
		ST_UP    = 6'b000100,
		ST_ON    = 6'b001000,
		ST_DOWN  = 6'b010000,
		ST_FAULT = 6'b100000
	} seq_state_t;

endpackage

// ==== src/hot_swap_sequencer_config.sv ====
`include "hot_swap_cfg.svh"

module hot_swap_sequencer_config
	import hot_swap_pkg::*;
#(
	parameter int                      CC_TICK_CYC =
		`CC_MAX_MS * `NS_PER_MS / `CC_CODE_MAX / `CLK_PERIOD_NS,
	parameter int                      VF_TICK_CYC = `VF_UNIT_MS * `NS_PER_MS / `CLK_PERIOD_NS,
	parameter logic [`USER_BITS-1:0]   NV_INIT     = 64'h0000_0000_0000_0000,
	parameter logic [`TRIM_BITS-1:0]   TRIM_INIT   = 17'h0_5A3C
)(
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  srst,
	// Board select and its serial link
	input  wire logic                  board_power_enable_n,
	input  wire link_in_t              link_in,
	output logic                       link_dout_o,
	output logic                       link_dout_oe,
	// Analog front end
	input  wire ana_in_t               ana_in,
	output cfg_out_t                   cfg_out,
	output logic [`NUM_CH-1:0]         ch_enable,
	output logic [`NUM_CH-1:0]         ch_latched_off,
	// Status
	output logic                       power_good_n_o,
	output logic                       power_good_n_oe,
	output logic                       sleep_mode,
	output logic                       link_locked
);

	// ---------------------------------------------------------------
	// Elaboration checks
	// ---------------------------------------------------------------
	if (CC_TICK_CYC < 1 || VF_TICK_CYC < 1) begin : g_bad_tick
		$error("tick counts must be at least one cycle");
	end

	// ---------------------------------------------------------------
	// Helper functions
	// ---------------------------------------------------------------
	// Channel ramped at step idx for an order code
	function automatic logic [1:0] order_ch(input logic [2:0] code, input logic [1:0] idx);
		logic [7:0] perm;
		perm = 8'hE4;
		case (code)
			3'h0: perm = 8'hE4;
			3'h1: perm = 8'h1B;
			3'h2: perm = 8'hD8;
			3'h3: perm = 8'h72;
			3'h4: perm = 8'hB4;
			3'h5: perm = 8'h4E;
			3'h6: perm = 8'hC6;
			3'h7: perm = 8'h39;
			default: perm = 8'hE4;
		endcase
		return perm[{idx, 1'b0} +: 2];
	endfunction

	// Filter length in ms units from its two-bit code
	function automatic logic [4:0] vf_len(input logic [1:0] code);
		case (code)
			2'h0: return `VF_LEN_0;
			2'h1: return `VF_LEN_1;
			2'h2: return `VF_LEN_2;
			2'h3: return `VF_LEN_3;
			default: return `VF_LEN_0;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Non-volatile store and link decode
	// ---------------------------------------------------------------
	// Store keeps its contents through srst, like the real cells
	logic [`USER_BITS-1:0] nv_r = NV_INIT;
	logic                  lk_clk_q_r;
	logic [3:0]            bit_cnt_r;
	logic [`ADDR_W:0]      hdr_r;
	logic                  link_act;
	logic                  link_rise;
	logic                  wr_pulse;
	logic [`ADDR_W-1:0]    addr;
	logic                  rd_bit;

	assign link_act  = link_in.frame & ~nv_r[`LOCK_BIT];
	assign link_rise = link_in.clk & ~lk_clk_q_r;
	assign addr      = hdr_r[`ADDR_W-1:0];
	assign wr_pulse  = link_act & link_rise & (bit_cnt_r == `HDR_BITS) & hdr_r[`ADDR_W];

	// Read mux over user store, factory trim, then zeros
	always_comb begin
		rd_bit = 1'b0;
		if (addr < `TRIM_BASE) begin
			rd_bit = nv_r[addr[5:0]];
		end else if (addr <= `ADDR_LAST) begin
			rd_bit = TRIM_INIT[5'(addr - `TRIM_BASE)];
		end
	end

	// Link clock edge detect
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lk_clk_q_r <= 1'b0;
		end else begin
			lk_clk_q_r <= link_in.clk;
		end
	end

	// Header shift: write flag then seven address bits, MSB first
	always_ff @(posedge clk_sys) begin
		if (srst || !link_act) begin
			bit_cnt_r <= 4'h0;
			hdr_r     <= '0;
		end else if (link_rise) begin
			if (bit_cnt_r < `HDR_BITS) begin
				hdr_r     <= {hdr_r[`ADDR_W-1:0], link_in.data};
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end else if (bit_cnt_r == `HDR_BITS) begin
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
		end
	end

	// Store write; factory area and out-of-range addresses are dropped
	always_ff @(posedge clk_sys) begin
		if (wr_pulse && addr < `TRIM_BASE) begin
			nv_r[addr[5:0]] <= link_in.data;
		end
	end

	// Read data drive, only during the data phase of a read frame
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			link_dout_o  <= 1'b0;
			link_dout_oe <= 1'b0;
		end else if (link_act && bit_cnt_r >= `HDR_BITS && !hdr_r[`ADDR_W]) begin
			link_dout_o  <= rd_bit;
			link_dout_oe <= 1'b1;
		end else begin
			link_dout_o  <= 1'b0;
			link_dout_oe <= 1'b0;
		end
	end

	// Lock status for software-free observation
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			link_locked <= 1'b0;
		end else begin
			link_locked <= nv_r[`LOCK_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Shadow of the sequencing fields
	// ---------------------------------------------------------------
	seq_state_t state_r;
	logic [7:0] cct_r;
	logic [2:0] ord_r;
	logic       rsp_latch_r;
	logic       rsp_rampdn_r;
	logic [1:0] rsp_vf_r;

	// Copy only in LOAD, so a write mid-sequence cannot disturb a ramp
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cfg_out      <= '0;
			cct_r        <= 8'h00;
			ord_r        <= 3'h0;
			rsp_latch_r  <= 1'b0;
			rsp_rampdn_r <= 1'b0;
			rsp_vf_r     <= 2'h0;
		end else if (state_r == ST_LOAD) begin
			cfg_out.undervoltage_coarse_range   <= nv_r[`UVR_LSB +: 8];
			cfg_out.uv_trim    <= nv_r[`UVT_LSB +: 16];
			cfg_out.ilim_range <= nv_r[`ILR_LSB +: 8];
			cfg_out.ilim_trim  <= nv_r[`ILT_LSB +: 16];
			cct_r              <= nv_r[`CCT_LSB +: 8];
			ord_r              <= nv_r[`ORD_LSB +: 3];
			rsp_latch_r        <= nv_r[`RSP_LATCH];
			rsp_rampdn_r       <= nv_r[`RSP_RAMPDN];
			rsp_vf_r           <= nv_r[`RSP_VF_LSB +: 2];
		end
	end

	// ---------------------------------------------------------------
	// Tick dividers
	// ---------------------------------------------------------------
	logic [31:0] cc_div_r;
	logic [31:0] vf_div_r;
	logic        cc_tick;
	logic        vf_tick;

	assign cc_tick = (cc_div_r == 32'(CC_TICK_CYC - 1));
	assign vf_tick = (vf_div_r == 32'(VF_TICK_CYC - 1));

	// Free-running enables; the first tick may come early by one unit
	always_ff @(posedge clk_sys) begin
		if (srst || cc_tick) begin
			cc_div_r <= 32'h0;
		end else begin
			cc_div_r <= cc_div_r + 32'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst || vf_tick) begin
			vf_div_r <= 32'h0;
		end else begin
			vf_div_r <= vf_div_r + 32'h1;
		end
	end

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	logic [1:0] step_r;
	logic [8:0] cc_cnt_r;
	logic [5:0] vf_cnt_r;
	logic [1:0] cur_ch;
	logic       cc_fault;
	logic       vf_fault;
	logic       oc_any;
	logic       uv_bad;

	assign cur_ch   = order_ch(ord_r, step_r);
	assign oc_any   = |(ana_in.oc_trip & ch_enable);
	assign cc_fault = (state_r == ST_UP) && ana_in.in_cc[cur_ch]
		&& cc_tick && (cc_cnt_r >= {1'b0, cct_r});
	assign uv_bad   = |(~ana_in.uv_ok & ch_enable);
	assign vf_fault = (state_r == ST_ON) && uv_bad
		&& (vf_cnt_r >= {1'b0, vf_len(rsp_vf_r)});

	// Constant-current time spent on the channel now ramping
	always_ff @(posedge clk_sys) begin
		if (srst || state_r != ST_UP || ana_in.uv_ok[cur_ch]) begin
			cc_cnt_r <= 9'h000;
		end else if (cc_tick && ana_in.in_cc[cur_ch] && !cc_cnt_r[8]) begin
			cc_cnt_r <= cc_cnt_r + 9'h001;
		end
	end

	// Voltage fault filter: restarts whenever all rails recover
	always_ff @(posedge clk_sys) begin
		if (srst || state_r != ST_ON || !uv_bad) begin
			vf_cnt_r <= 6'h00;
		end else if (vf_tick && !vf_cnt_r[5]) begin
			vf_cnt_r <= vf_cnt_r + 6'h01;
		end
	end

	// State, step index and channel switches
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_r        <= ST_SLEEP;
			step_r         <= 2'h0;
			ch_enable      <= '0;
			ch_latched_off <= '0;
		end else begin
			case (state_r)
				ST_SLEEP: begin
					ch_latched_off <= '0;
					if (!board_power_enable_n) begin
						state_r <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					step_r  <= 2'h0;
					state_r <= board_power_enable_n ? ST_SLEEP : ST_UP;
				end
				ST_UP: begin
					ch_enable[cur_ch] <= 1'b1;
					if (oc_any || cc_fault) begin
						state_r <= ST_FAULT;
						if (rsp_latch_r && oc_any) begin
							ch_enable      <= ch_enable & ~ana_in.oc_trip;
							ch_latched_off <= ana_in.oc_trip & ch_enable;
						end
						if (!rsp_rampdn_r) begin
							ch_enable <= '0;
						end
					end else if (board_power_enable_n) begin
						state_r <= ST_DOWN;
					end else if (ana_in.uv_ok[cur_ch]) begin
						if (step_r == 2'h3) begin
							state_r <= ST_ON;
						end else begin
							step_r <= step_r + 2'h1;
						end
					end
				end
				ST_ON: begin
					if (oc_any || vf_fault) begin
						state_r <= ST_FAULT;
						if (rsp_latch_r && oc_any) begin
							ch_enable      <= ch_enable & ~ana_in.oc_trip;
							ch_latched_off <= ana_in.oc_trip & ch_enable;
						end
						if (!rsp_rampdn_r) begin
							ch_enable <= '0;
						end
					end else if (board_power_enable_n) begin
						state_r <= ST_DOWN;
					end
				end
				ST_DOWN, ST_FAULT: begin
					// Ramp down in reverse order, skipping channels already off
					if (!ch_enable[cur_ch] || !ana_in.uv_ok[cur_ch]) begin
						ch_enable[cur_ch] <= 1'b0;
						if (step_r != 2'h0) begin
							step_r <= step_r - 2'h1;
						end else if (ch_enable == '0 || state_r == ST_DOWN) begin
							if (board_power_enable_n) begin
								state_r <= ST_SLEEP;
							end
						end
					end else begin
						ch_enable[cur_ch] <= 1'b0;
					end
				end
				default: begin
					state_r   <= ST_SLEEP;
					ch_enable <= '0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Status outputs
	// ---------------------------------------------------------------
	// Open drain: pull low only while on, with no trip and no expired voltage filter
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			power_good_n_o  <= 1'b0;
			power_good_n_oe <= 1'b0;
			sleep_mode      <= 1'b1;
		end else begin
			power_good_n_o  <= 1'b0;
			power_good_n_oe <= (state_r == ST_ON) && !oc_any && !vf_fault;
			sleep_mode      <= (state_r == ST_SLEEP);
		end
	end

endmodule

// ==== verif/hot_swap_checker.sv ====
`include "hot_swap_cfg.svh"

// ----
// Port checks of sequencer and link
// ----
module hot_swap_checker
	import hot_swap_pkg::*;
(
	// Clock and reset
	input wire logic		clk_sys,
	input wire logic		srst,
	// Board select and link
	input wire logic		board_power_enable_n,
	input wire link_in_t		link_in,
	input wire logic		link_dout_o,
	input wire logic		link_dout_oe,
	// Analog side
	input wire ana_in_t		ana_in,
	input wire cfg_out_t		cfg_out,
	input wire logic [`NUM_CH-1:0]	ch_enable,
	input wire logic [`NUM_CH-1:0]	ch_latched_off,
	// Status
	input wire logic		power_good_n_o,
	input wire logic		power_good_n_oe,
	input wire logic		sleep_mode,
	input wire logic		link_locked
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	// Sleep keeps every switch open and the pin released
	sleep_quiet_a: assert property (sleep_mode |-> ch_enable == 4'h0 && !power_good_n_oe)
		else $error("switch or power_good_n active in sleep");
	// Open drain: only ever pulls low
	pin_low_a: assert property (power_good_n_o == 1'b0)
		else $error("power_good_n pin driven high");
	power_good_n_rise_a: assert property ($rose(power_good_n_oe) |-> ch_enable == 4'hF)
		else $error("power_good_n before all rails on");
	// A trip on a live rail must release power_good_n quickly
	trip_drop_a: assert property (|(ana_in.oc_trip & ch_enable) && power_good_n_oe
		|-> ##[1:2] !power_good_n_oe) else $error("power_good_n kept after trip");
	latch_off_a: assert property (|ch_latched_off |=> (ch_latched_off & ch_enable) == 4'h0)
		else $error("latched channel still on");
	lock_keep_a: assert property (link_locked |=> link_locked)
		else $error("lock released");
	lock_quiet_a: assert property (link_locked |-> !link_dout_oe)
		else $error("link answers while locked");
	// Fields may only move while nothing is switched on
	load_first_a: assert property ($changed(cfg_out) |-> ch_enable == 4'h0)
		else $error("fields changed while sequencing");

	cover property ($rose(power_good_n_oe));
	cover property ($rose(|ch_latched_off));
	cover property ($rose(link_locked));
endmodule

bind hot_swap_sequencer_config hot_swap_checker u_chk (
	.clk_sys(clk_sys), .srst(srst), .board_power_enable_n(board_power_enable_n),
	.link_in(link_in), .link_dout_o(link_dout_o), .link_dout_oe(link_dout_oe),
	.ana_in(ana_in), .cfg_out(cfg_out), .ch_enable(ch_enable),
	.ch_latched_off(ch_latched_off), .power_good_n_o(power_good_n_o),
	.power_good_n_oe(power_good_n_oe), .sleep_mode(sleep_mode), .link_locked(link_locked));

// ==== verif/host_link_model.sv ====
// ----
// Host programmer on the board select link
// ----
module host_link_model
	import hot_swap_pkg::*;
(
	// Clock
	input wire logic	clk_sys,
	// Link levels
	output link_in_t	link_in,
	input wire logic	link_dout_o,
	input wire logic	link_dout_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	initial link_in = '0;

	// One bit: clock low with data, then a rise
	task automatic bit_out(input logic b);
		@(posedge clk_sys);
		link_in.clk <= 1'b0;
		link_in.data <= b;
		@(posedge clk_sys);
		link_in.clk <= 1'b1;
	endtask

	// Write flag then address, MSB first
	task automatic hdr(input logic w, input logic [6:0] a);
		int i;
		@(posedge clk_sys);
		link_in.frame <= 1'b1;
		bit_out(w);
		for (i = 6; i >= 0; i--)
			bit_out(a[i]);
	endtask

	// Released data shows the inverse so stale levels never pass
	task automatic done;
		@(posedge clk_sys);
		link_in <= {1'b0, 1'b0, ~link_in.data};
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [6:0] a, input logic d);
		hdr(1'b1, a);
		bit_out(d);
		done();
	endtask

	task automatic rd(input logic [6:0] a, output logic q, output logic seen);
		hdr(1'b0, a);
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		q = link_dout_o;
		seen = link_dout_oe;
		done();
	endtask
endmodule

// ==== verif/test_hot_swap_sequencer_config.sv ====
module test_hot_swap_sequencer_config
	import hot_swap_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [16:0]	TRIM = 17'h0_5A3C; // Arbitrary factory pattern
	localparam logic [7:0]	PERM [8] = '{8'hE4, 8'h1B, 8'hD8, 8'h72, 8'hB4, 8'h4E, 8'hC6, 8'h39};

	logic		clk_sys = 1'b0;
	logic		srst = 1'b1;
	logic		board_power_enable_n = 1'b1;
	ana_in_t	ana_in = '0;
	link_in_t	link_in;
	cfg_out_t	cfg_out;
	logic		link_dout_o, link_dout_oe, power_good_n_o, power_good_n_oe;
	logic		sleep_mode, link_locked;
	logic [3:0]	ch_enable, ch_latched_off;
	bit [80:0]	mem_m; // Bench copy of the whole store
	int		fails = 0;
	int		num_checks = 0;
	integer		seed = 32'h8E80D758;
	int		code;

	always #5 clk_sys = ~clk_sys;

	// Short ticks keep timers within a brief run
	hot_swap_sequencer_config #(.CC_TICK_CYC(4), .VF_TICK_CYC(4), .TRIM_INIT(TRIM)) u_dut (
		.clk_sys(clk_sys), .srst(srst), .board_power_enable_n(board_power_enable_n),
		.link_in(link_in), .link_dout_o(link_dout_o), .link_dout_oe(link_dout_oe),
		.ana_in(ana_in), .cfg_out(cfg_out), .ch_enable(ch_enable),
		.ch_latched_off(ch_latched_off), .power_good_n_o(power_good_n_o),
		.power_good_n_oe(power_good_n_oe), .sleep_mode(sleep_mode), .link_locked(link_locked));
	host_link_model u_host (.clk_sys(clk_sys), .link_in(link_in), .link_dout_o(link_dout_o),
		.link_dout_oe(link_dout_oe));

	task automatic report_and_stop;
		if (fails == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask

	// Watched output by number: 0-3 rail switch, 4 power_good_n, 5 sleep, 6 lock
	function automatic logic probe(input int sel);
		case (sel)
			4: return power_good_n_oe;
			5: return sleep_mode;
			6: return link_locked;
			default: return ch_enable[sel[1:0]];
		endcase
	endfunction

	// Bounded wait, sampled only at falling edges; running out ends the run
	task automatic wait_lvl(input int sel, input logic lvl);
		int k;
		for (k = 0; k < 60; k++) begin
			@(negedge clk_sys);
			if (probe(sel) === lvl)
				break;
		end
		if (probe(sel) !== lvl) begin
			fails++;
			report_and_stop();
		end
	endtask

	// Walks the order code up, or in reverse down, one rail at a time
	task automatic ramp(input logic up);
		int s;
		logic [1:0] ch;
		logic [3:0] mask;
		mask = {4{~up}};
		for (s = 0; s < 4; s++) begin
			ch = up ? PERM[code][2*s+:2] : PERM[code][6-2*s+:2];
			mask[ch] = up;
			wait_lvl(ch, up);
			check(ch_enable, mask, "ramp step");
			@(posedge clk_sys);
			ana_in.uv_ok[ch] <= up;
		end
	endtask

	initial begin
		int i;
		logic q;
		logic seen;
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		check({sleep_mode, power_good_n_oe, link_locked}, 3'b100, "reset state");
		code = $random(seed) & 7;
		mem_m[63:0] = {$random(seed), $random(seed)};
		mem_m[63:56] = {5'b00011, code[2:0]}; // Latch and ordered ramp-down
		mem_m[80:64] = TRIM;
		for (i = 0; i < 64; i++)
			u_host.wr(i[6:0], mem_m[i]);
		u_host.wr(7'h46, ~TRIM[6]);
		for (i = 0; i < 86; i++) begin
			u_host.rd(i[6:0], q, seen);
			check(q, (i < 81) ? mem_m[i] : 1'b0, "read back");
			if (i < 81)
				check(seen, 1'b1, "read driven");
		end
		board_power_enable_n <= 1'b0;
		ramp(1'b1);
		wait_lvl(4, 1'b1);
		check(cfg_out, {mem_m[7:0], mem_m[23:8], mem_m[31:24], mem_m[47:32]}, "fields");
		@(posedge clk_sys);
		board_power_enable_n <= 1'b1;
		ramp(1'b0);
		wait_lvl(5, 1'b1);
		@(posedge clk_sys);
		board_power_enable_n <= 1'b0;
		ramp(1'b1);
		wait_lvl(4, 1'b1);
		@(posedge clk_sys);
		ana_in.oc_trip[PERM[code][1:0]] <= 1'b1;
		wait_lvl(4, 1'b0);
		@(negedge clk_sys);
		check(ch_latched_off, 4'h1 << PERM[code][1:0], "latched rail");
		@(posedge clk_sys);
		ana_in <= '0;
		board_power_enable_n <= 1'b1;
		wait_lvl(5, 1'b1);
		check({ch_latched_off, ch_enable}, 8'h00, "cleared in sleep");
		// Allowance of two units, then the first rail stuck in current limit
		for (i = 48; i < 56; i++) begin
			mem_m[i] = (i == 49);
			u_host.wr(i[6:0], mem_m[i]);
		end
		board_power_enable_n <= 1'b0;
		ana_in.in_cc[PERM[code][1:0]] <= 1'b1;
		wait_lvl(PERM[code][1:0], 1'b1);
		wait_lvl(PERM[code][1:0], 1'b0);
		check({ch_enable, ch_latched_off, power_good_n_oe}, 9'h000, "current time-out");
		@(posedge clk_sys);
		ana_in <= '0;
		board_power_enable_n <= 1'b1;
		wait_lvl(5, 1'b1);
		// Rail lost while on; the filter is set to zero ticks
		@(posedge clk_sys);
		board_power_enable_n <= 1'b0;
		ramp(1'b1);
		wait_lvl(4, 1'b1);
		@(posedge clk_sys);
		ana_in.uv_ok[PERM[code][3:2]] <= 1'b0;
		wait_lvl(4, 1'b0);
		check(ch_latched_off, 4'h0, "no latch on voltage fault");
		u_host.wr(7'h3F, 1'b1);
		wait_lvl(6, 1'b1);
		u_host.rd(7'h00, q, seen);
		check(seen, 1'b0, "link detached");
		report_and_stop();
	end
endmodule
